/* File: hw/mas_top.sv */
`timescale 1ns/10ps
`include "mas_consts.svh"
// address match, type compare, phy mode and first statistics counters
module mas_top
  import mas_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_clk_pin,  // transceiver clock from the pin
  input  wire mas_rx_evt_t rx_evt,      // same-clock receive report
  input  wire mas_tx_evt_t tx_evt,      // same-clock transmit report
  input  wire logic [47:0] rx_dest,     // destination of current frame
  output logic             rmii_mode,   // reduced interface selected
  output logic             xcvr_clk_en, // gated transceiver clock pulse
  output logic [2:0]       addr_hit,    // match of address two..four
  output logic             type_hit     // type field equals programmed value
);
  typedef struct packed {
    logic [31:0] sa_lo2;
    logic [15:0] sa_hi2;
    logic [31:0] sa_lo3;
    logic [15:0] sa_hi3;
    logic [31:0] sa_lo4;
    logic [15:0] sa_hi4;
    logic [15:0] type_identifier_value;
    logic        rmii;
    logic        transceiver_clock_enable;
    logic        rx_enable;
    logic        stat_wr_enable;
    logic        jumbo;
    logic        clk_prev;
    logic        clk_pulse;
    logic [2:0]  hit;
    logic        thit;
    logic [31:0] rdata;
  } mas_top_st_t;
  mas_top_st_t st_reg;
  mas_top_st_t st_next;

  // register map, byte offsets on the 32-bit register bus:
  //   0x00 / 0x04  address slot two, low word then high word
  //   0x08 / 0x0C  address slot three, low word then high word
  //   0x10 / 0x14  address slot four, low word then high word
  //   0x18         programmed type value, low sixteen bits
  //   0x1C         interface mode and transceiver clock enable
  //   0x20         good pause frame counter, clear on read
  //   0x24         sent-ok frame counter, clear on read
  //   0x28         one-collision frame counter, clear on read
  //   0x2C         receive enable, counter write enable, jumbo length
  //   0x30         match flags of the last received frame
  // only whole aligned words are decoded; any other offset is refused
  // with pslverr and leaves every register as it was

  // bus phase decode
  logic                     acc;        // access phase completing
  logic                     wr_acc;     // write access completing
  logic                     rd_setup;   // read setup: snapshot and clear
  // transceiver clock path
  logic                     clk_s;      // synchronised transceiver clock
  // frame qualification for the statistics counters
  logic                     good_rx;    // length and error tests passed
  logic [15:0]              max_len;    // upper length limit in force
  // counter values as they stand
  logic [`MAS_PAUSE_W-1:0]  pause_val;  // good pause frames
  logic [`MAS_SENT_W-1:0]   sent_val;   // frames sent ok
  logic [`MAS_ONECOL_W-1:0] onecol_val; // frames sent after one collision
  // one-cycle count requests
  logic                     pause_inc;  // count one pause frame
  logic                     sent_inc;   // count one sent frame
  logic                     onecol_inc; // count one single-collision frame
  // software side of the counters
  logic                     stat_we;    // counter write permitted
  logic                     pause_clr;  // pause counter read
  logic                     sent_clr;   // sent counter read
  logic                     onecol_clr; // one-collision counter read
  logic                     pause_wr;   // pause counter written
  logic                     sent_wr;    // sent counter written
  logic                     onecol_wr;  // one-collision counter written

  // known offset check, used by the error response
  function automatic logic mapped(input logic [11:0] a);
    case (a)
      `MAS_OFF_SA2_LO, `MAS_OFF_SA2_HI, `MAS_OFF_SA3_LO, `MAS_OFF_SA3_HI,
      `MAS_OFF_SA4_LO, `MAS_OFF_SA4_HI, `MAS_OFF_TYPE, `MAS_OFF_PHYCTL,
      `MAS_OFF_PAUSE, `MAS_OFF_SENT, `MAS_OFF_ONECOL, `MAS_OFF_CTRL,
      `MAS_OFF_STATUS: mapped = 1'b1;
      default:         mapped = 1'b0;
    endcase
  endfunction : mapped

  // one register selected; shared by the counter read and write strobes
  function automatic logic at_off(input logic [11:0] a, input logic [11:0] off);
    at_off = (a == off);
  endfunction : at_off

  // 48-bit address compare; bit 0 of the low word is the first bit on the
  // wire, which is also the unicast / multicast flag of the frame
  function automatic logic addr_eq(input logic [31:0] lo, input logic [15:0] hi,
                                   input logic [47:0] d);
    addr_eq = (d == {hi, lo});
  endfunction : addr_eq

  // transceiver clock pin crosses into the pclk domain through two flops;
  // the pin runs far below pclk, so every pin edge is seen exactly once
  mas_sync u_clk_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (tx_clk_pin),
    .dout    (clk_s)
  );

  // bus phase decode
  // pready is tied high, so every access phase lasts exactly one cycle
  assign acc      = psel && penable;
  assign wr_acc   = acc && pwrite;
  // read data is captured at the setup edge; the counters clear at that
  // same edge, so an event landing between snapshot and clear is never lost
  assign rd_setup = psel && !penable && !pwrite;

  // frame length window widens with the jumbo bit
  assign max_len = st_reg.jumbo ? `MAS_MAX_LEN_BIG : `MAS_MAX_LEN;
  // a good frame is inside the window and carries no error flag
  assign good_rx = rx_evt.done && (rx_evt.len >= `MAS_MIN_LEN) &&
                   (rx_evt.len <= max_len) && !rx_evt.fcs_err &&
                   !rx_evt.align_err && !rx_evt.sym_err;
  // receive counting only while receive is enabled
  assign pause_inc  = good_rx && rx_evt.is_pause && st_reg.rx_enable;
  // a sent frame had no underrun and stayed inside the retry limit
  assign sent_inc   = tx_evt.done && !tx_evt.underrun && !tx_evt.retry_lim;
  // exactly one collision on an otherwise good transmission
  assign onecol_inc = sent_inc && (tx_evt.collisions == `MAS_ONE_COLL);

  // counters writable only with the statistics write bit; without it the
  // write still completes on the bus but the counter keeps its value
  assign stat_we    = wr_acc && st_reg.stat_wr_enable;
  assign pause_wr   = stat_we && at_off(paddr, `MAS_OFF_PAUSE);
  assign sent_wr    = stat_we && at_off(paddr, `MAS_OFF_SENT);
  assign onecol_wr  = stat_we && at_off(paddr, `MAS_OFF_ONECOL);
  // read side effect, one strobe per counter
  assign pause_clr  = rd_setup && at_off(paddr, `MAS_OFF_PAUSE);
  assign sent_clr   = rd_setup && at_off(paddr, `MAS_OFF_SENT);
  assign onecol_clr = rd_setup && at_off(paddr, `MAS_OFF_ONECOL);

  // good pause frames; counts only receive-side events
  // software should read it before it sticks at all ones
  mas_stat_counter #(.W(`MAS_PAUSE_W)) u_pause (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (pause_inc),
    .rd_clr  (pause_clr),
    .wr_en   (pause_wr),
    .wr_data (pwdata[`MAS_PAUSE_W-1:0]),
    .value   (pause_val)
  );

  // frames sent without underrun or retry overflow
  // the widest counter, it fills the low three bytes of its word
  mas_stat_counter #(.W(`MAS_SENT_W)) u_sent (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (sent_inc),
    .rd_clr  (sent_clr),
    .wr_en   (sent_wr),
    .wr_data (pwdata[`MAS_SENT_W-1:0]),
    .value   (sent_val)
  );

  // frames sent after exactly one collision
  // every event here is also counted as a sent frame
  mas_stat_counter #(.W(`MAS_ONECOL_W)) u_onecol (
    .pclk    (pclk),
    .presetn (presetn),
    .inc     (onecol_inc),
    .rd_clr  (onecol_clr),
    .wr_en   (onecol_wr),
    .wr_data (pwdata[`MAS_ONECOL_W-1:0]),
    .value   (onecol_val)
  );

  // one combinational copy of the whole register state:
  //   1. software writes of the plain registers
  //   2. read data snapshot in the setup cycle
  //   3. edge detect and gate of the transceiver clock
  //   4. address and type match at the end of each frame
  always_comb begin
    st_next = st_reg;
    // 1. plain register writes; counters are written inside their own modules
    if (wr_acc) begin
      case (paddr)
        `MAS_OFF_SA2_LO: st_next.sa_lo2 = pwdata;
        // high words keep sixteen bits; the upper half is not stored at all
        `MAS_OFF_SA2_HI: st_next.sa_hi2 = pwdata[15:0];
        `MAS_OFF_SA3_LO: st_next.sa_lo3 = pwdata;
        `MAS_OFF_SA3_HI: st_next.sa_hi3 = pwdata[15:0];
        `MAS_OFF_SA4_LO: st_next.sa_lo4 = pwdata;
        `MAS_OFF_SA4_HI: st_next.sa_hi4 = pwdata[15:0];
        // type value for the compare against the type/length field
        `MAS_OFF_TYPE:   st_next.type_identifier_value = pwdata[15:0];
        // interface mode and clock gate; bits above one are ignored
        `MAS_OFF_PHYCTL: begin
          st_next.rmii                     = pwdata[`MAS_PHY_RMII];
          st_next.transceiver_clock_enable = pwdata[`MAS_PHY_XCLK];
        end
        // local stand-in for the network control and configuration bits
        `MAS_OFF_CTRL: begin
          st_next.rx_enable      = pwdata[`MAS_CTRL_RXEN];
          st_next.stat_wr_enable = pwdata[`MAS_CTRL_STATWE];
          st_next.jumbo          = pwdata[`MAS_CTRL_JUMBO];
        end
        default: ; // counters, status and unmapped offsets
      endcase
    end
    // 2. read data is registered at the setup edge and stands through the
    //    access cycle; outside a read it returns to zero
    st_next.rdata = `MAS_ZERO32;
    if (rd_setup) begin
      case (paddr)
        `MAS_OFF_SA2_LO: st_next.rdata = st_reg.sa_lo2;
        // reserved upper halves read as zero
        `MAS_OFF_SA2_HI: st_next.rdata = {16'h0000, st_reg.sa_hi2};
        `MAS_OFF_SA3_LO: st_next.rdata = st_reg.sa_lo3;
        `MAS_OFF_SA3_HI: st_next.rdata = {16'h0000, st_reg.sa_hi3};
        `MAS_OFF_SA4_LO: st_next.rdata = st_reg.sa_lo4;
        `MAS_OFF_SA4_HI: st_next.rdata = {16'h0000, st_reg.sa_hi4};
        `MAS_OFF_TYPE:   st_next.rdata = {16'h0000, st_reg.type_identifier_value};
        `MAS_OFF_PHYCTL: st_next.rdata = {30'h0,
                                          st_reg.transceiver_clock_enable, st_reg.rmii};
        // counters: the snapshot is taken at the edge that clears them
        `MAS_OFF_PAUSE:  st_next.rdata = {16'h0000, pause_val};
        `MAS_OFF_SENT:   st_next.rdata = {8'h00, sent_val};
        `MAS_OFF_ONECOL: st_next.rdata = {16'h0000, onecol_val};
        `MAS_OFF_CTRL:   st_next.rdata = {23'h0, st_reg.jumbo, st_reg.stat_wr_enable,
                                          6'h00, st_reg.rx_enable};
        // match flags of the last frame, type flag above the address flags
        `MAS_OFF_STATUS: st_next.rdata = {28'h000_0000, st_reg.thit, st_reg.hit};
        default:         st_next.rdata = `MAS_ZERO32;
      endcase
    end
    // 3. rising edge of the synchronised transceiver clock, one pulse per
    //    edge, passed only while the clock enable bit is set; the pulse
    //    lags the pin by the two synchroniser flops and the edge detector
    st_next.clk_prev  = clk_s;
    st_next.clk_pulse = clk_s && !st_reg.clk_prev &&
                        st_reg.transceiver_clock_enable;
    // 4. matches are sampled at the end of each received frame and hold
    //    until the next one; software sees them in the status word
    if (rx_evt.done) begin
      st_next.hit[0] = addr_eq(st_reg.sa_lo2, st_reg.sa_hi2, rx_dest);
      st_next.hit[1] = addr_eq(st_reg.sa_lo3, st_reg.sa_hi3, rx_dest);
      st_next.hit[2] = addr_eq(st_reg.sa_lo4, st_reg.sa_hi4, rx_dest);
      st_next.thit   = (rx_evt.type_len == st_reg.type_identifier_value);
    end
  end

  // state register; reset clears every field, so the mode is full MII,
  // the transceiver clock is gated off and all match flags are low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // bus answer
  assign prdata      = st_reg.rdata;
  assign pready      = 1'b1;                  // zero wait states
  assign pslverr     = acc && !mapped(paddr); // unmapped offset refused
  // link side and match results, all straight from flops
  assign rmii_mode   = st_reg.rmii;
  assign xcvr_clk_en = st_reg.clk_pulse;
  assign addr_hit    = st_reg.hit;
  assign type_hit    = st_reg.thit;
endmodule : mas_top

/* File: hw/mas_consts.svh */
// Functional notes
// - address low word; bit0 unicast/multicast first bit
// - hold 16-bit type id, compare received type
// - interface-select one means reduced mode
// - clock enable gates transceiver input clock
// - counter read returns value then clears
// - counters saturate at all ones
// - receive counters count only while enabled
// - counter writes need control bit 7
// - 16-bit good pause frame counter
// - configuration bit 8 raises limit to 1536
// - 24-bit sent-ok frame counter
// - 16-bit single collision frame counter
`ifndef MAS_CONSTS_SVH
`define MAS_CONSTS_SVH
`define MAS_OFF_SA2_LO   12'h000
`define MAS_OFF_SA2_HI   12'h004
`define MAS_OFF_SA3_LO   12'h008
`define MAS_OFF_SA3_HI   12'h00C
`define MAS_OFF_SA4_LO   12'h010
`define MAS_OFF_SA4_HI   12'h014
`define MAS_OFF_TYPE     12'h018
`define MAS_OFF_PHYCTL   12'h01C
`define MAS_OFF_PAUSE    12'h020
`define MAS_OFF_SENT     12'h024
`define MAS_OFF_ONECOL   12'h028
`define MAS_OFF_CTRL     12'h02C
`define MAS_OFF_STATUS   12'h030
`define MAS_CTRL_RXEN    0
`define MAS_CTRL_STATWE  7
`define MAS_CTRL_JUMBO   8
`define MAS_PHY_RMII     0
`define MAS_PHY_XCLK     1
`define MAS_MIN_LEN      16'h0040
`define MAS_MAX_LEN      16'h05EE
`define MAS_MAX_LEN_BIG  16'h0600
`define MAS_PAUSE_W      16
`define MAS_SENT_W       24
`define MAS_ONECOL_W     16
`define MAS_ONE_COLL     5'h01
`define MAS_ZERO32       32'h0000_0000
`endif

/* File: hw/mas_pkg.sv */
package mas_pkg;
  // one received frame report from the receive engine
  typedef struct packed {
    logic        done;     // one-cycle end of frame
    logic        is_pause; // pause frame
    logic [15:0] len;      // length in bytes
    logic        fcs_err;
    logic        align_err;
    logic        sym_err;
    logic [15:0] type_len; // type/length field
  } mas_rx_evt_t;
  // one transmit completion report
  typedef struct packed {
    logic       done;      // one-cycle end of attempt
    logic       underrun;
    logic       retry_lim;
    logic [4:0] collisions;
  } mas_tx_evt_t;
endpackage : mas_pkg

/* File: hw/mas_sync.sv */
`timescale 1ns/10ps
// two-flop synchroniser; first flop read only by the second
module mas_sync
  import mas_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } mas_sync_st_t;
  mas_sync_st_t st_reg;
  mas_sync_st_t st_next;

  // shift one place per clock
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.s2;
endmodule : mas_sync

/* File: hw/mas_stat_counter.sv */
`timescale 1ns/10ps
// saturating clear-on-read statistics counter
module mas_stat_counter
  import mas_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         inc,      // one counted event
  input  wire logic         rd_clr,   // read setup phase, same edge as the snapshot
  input  wire logic         wr_en,    // permitted software write
  input  wire logic [W-1:0] wr_data,
  output logic      [W-1:0] value
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } mas_cnt_st_t;
  mas_cnt_st_t st_reg;
  mas_cnt_st_t st_next;

  // write beats read-clear; an event in the clearing cycle is kept as one
  always_comb begin
    st_next = st_reg;
    if (wr_en) begin
      st_next.cnt = wr_data;
    end else if (rd_clr) begin
      st_next.cnt = inc ? W'(1) : '0;
    end else if (inc && (st_reg.cnt != '1)) begin
      st_next.cnt = st_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign value = st_reg.cnt;
endmodule : mas_stat_counter

/* File: testbench/mas_checker.sv */
`timescale 1ns/10ps
// port-level checks of the match and statistics slice
module mas_checker
  import mas_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire mas_rx_evt_t rx_evt,
  input wire logic        rmii_mode,
  input wire logic        xcvr_clk_en,
  input wire logic [2:0]  addr_hit,
  input wire logic        type_hit
);
  logic [15:0] type_shadow; // shadow of the programmed type value
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  // shadow kept here so no design internals are needed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) type_shadow <= 16'h0000;
    else if (wr && paddr == 12'h018) type_shadow <= pwdata[15:0];
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  hi_zero_a: assert property (
    rd && ((paddr[2] && paddr < 12'h018) || paddr == 12'h018) |-> prdata[31:16] == 16'h0000)
    else $error("reserved upper half not zero");
  type_cmp_a: assert property (
    rx_evt.done |=> type_hit == ($past(rx_evt.type_len) == $past(type_shadow)))
    else $error("type compare wrong");
  rmii_follow_a: assert property (
    wr && paddr == 12'h01C |=> rmii_mode == $past(pwdata[0]))
    else $error("interface mode not taken");
  clk_pulse_a: assert property (xcvr_clk_en |=> !xcvr_clk_en)
    else $error("clock pulse longer than one cycle");
  clk_gate_a: assert property (
    wr && paddr == 12'h01C && !pwdata[1] |=> ##1 !xcvr_clk_en [*8])
    else $error("gated clock still pulsing");
  match_hold_a: assert property (
    !$past(rx_evt.done) |-> $stable(addr_hit) && $stable(type_hit))
    else $error("match flags moved without frame");
  cnt_width_a: assert property (
    rd && paddr[11:4] == 8'h02 && paddr[3:0] < 4'hC
      |-> prdata[31:24] == 8'h00 && (paddr == 12'h024 || prdata[23:16] == 8'h00))
    else $error("counter wider than allowed");
  unmapped_err_a: assert property (psel && penable && paddr > 12'h030 |-> pslverr && pready)
    else $error("unmapped access not refused");
endmodule : mas_checker
bind mas_top mas_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt), .rmii_mode(rmii_mode),
  .xcvr_clk_en(xcvr_clk_en), .addr_hit(addr_hit), .type_hit(type_hit));

/* File: testbench/mas_phy_model.sv */
`timescale 1ns/10ps
// transceiver side: free-running transmit clock, unrelated phase
module mas_phy_model #(
  parameter realtime HALF = 62.5 // half of a 125 ns period
) (
  output logic tx_clk
);
  initial begin
    tx_clk = 1'b0;
    #13;
    forever #(HALF) tx_clk = ~tx_clk;
  end
endmodule : mas_phy_model

/* File: testbench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import mas_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        tx_clk_pin, rmii_mode, xcvr_clk_en, type_hit;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [47:0] rx_dest;
  logic [2:0]  addr_hit;
  mas_rx_evt_t rx_evt;
  mas_tx_evt_t tx_evt;
  int          fails, checks, n;
  int          cyc = 0;
  mas_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clk_pin(tx_clk_pin), .rx_evt(rx_evt), .tx_evt(tx_evt),
    .rx_dest(rx_dest), .rmii_mode(rmii_mode), .xcvr_clk_en(xcvr_clk_en),
    .addr_hit(addr_hit), .type_hit(type_hit));
  mas_phy_model phy (.tx_clk(tx_clk_pin));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // hang guard, the run needs only a few hundred cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      close_out;
    end
  end
  task close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  // one apb transfer; the answer is taken at the edge that sees pready high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    logic rdy;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      rdy = pready;
      r = prdata;
      e = pslverr;
    end while (rdy !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0000_0000, r, e);
    chk($sformatf("reg %h", a), x, r);
  endtask : rd
  task rxf(input logic [15:0] l, input logic p, input logic [2:0] er, input logic [15:0] t);
    @(posedge pclk);
    rx_evt <= '{1'b1, p, l, er[2], er[1], er[0], t};
    @(posedge pclk);
    rx_evt.done <= 1'b0;
  endtask : rxf
  task txf(input logic u, input logic rl, input logic [4:0] c);
    @(posedge pclk);
    tx_evt <= '{1'b1, u, rl, c};
    @(posedge pclk);
    tx_evt.done <= 1'b0;
  endtask : txf
  task t_regs;
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 8; i++) begin
      rd(12'(i * 4), 32'h0000_0000);
      wr(12'(i * 4), 32'hFFFF_FFFF);
      rd(12'(i * 4), i == 7 ? 32'h3 : (i % 2 || i == 6) ? 32'hFFFF : 32'hFFFF_FFFF);
    end
    chk("rmii_mode", 1'b1, rmii_mode);
    xfer(1'b0, 12'h040, 32'h0000_0000, r, e);
    chk("pslverr", 1'b1, e);
    $display("registers done");
  endtask : t_regs
  task t_match;
    wr(12'h008, 32'hDDCC_BBA1);
    wr(12'h00C, 32'h0000_FF11);
    wr(12'h018, 32'h0000_88B5);
    rx_dest <= 48'hFF11_DDCC_BBA1;
    rxf(16'h0100, 1'b0, 3'b000, 16'h88B5);
    @(posedge pclk);
    chk("addr_hit", 3'b010, addr_hit);
    chk("type_hit", 1'b1, type_hit);
    rxf(16'h0100, 1'b0, 3'b000, 16'h88B4);
    @(posedge pclk);
    chk("type_hit", 1'b0, type_hit);
    rx_dest <= 48'hFFFF_FFFF_FFFF;
    rxf(16'h0100, 1'b0, 3'b000, 16'h88B5);
    @(posedge pclk);
    chk("addr_hit", 3'b101, addr_hit);
    rd(12'h030, 32'h0000_000D);
    $display("match done");
  endtask : t_match
  task t_clk;
    for (int en = 1; en >= 0; en--) begin
      wr(12'h01C, 32'(en * 2));
      repeat (8) @(posedge pclk);
      n = 0;
      repeat (100) @(negedge pclk) n += xcvr_clk_en;
      chk("pulses", 32'd1, 32'(en ? (n >= 6 && n <= 7) : (n == 0)));
      chk("rmii_mode", 1'b0, rmii_mode);
    end
    $display("clock gate done");
  endtask : t_clk
  task t_rx;
    wr(12'h02C, 32'h1);
    rxf(16'd64, 1'b1, 3'b000, 16'h8808);
    rxf(16'd1518, 1'b1, 3'b000, 16'h8808);
    rxf(16'd1519, 1'b1, 3'b000, 16'h8808);
    rxf(16'd63, 1'b1, 3'b000, 16'h8808);
    rxf(16'd100, 1'b0, 3'b000, 16'h8808);
    for (int b = 0; b < 3; b++) rxf(16'd100, 1'b1, 3'(1 << b), 16'h8808);
    rd(12'h020, 32'd2);
    rd(12'h020, 32'd0);
    wr(12'h02C, 32'h101);
    rxf(16'd1536, 1'b1, 3'b000, 16'h8808);
    rxf(16'd1537, 1'b1, 3'b000, 16'h8808);
    rd(12'h020, 32'd1);
    wr(12'h02C, 32'h0);
    rxf(16'd64, 1'b1, 3'b000, 16'h8808);
    rd(12'h020, 32'd0);
    $display("receive count done");
  endtask : t_rx
  task t_tx;
    txf(1'b0, 1'b0, 5'd1);
    txf(1'b0, 1'b0, 5'd0);
    txf(1'b1, 1'b0, 5'd1);
    txf(1'b0, 1'b1, 5'd1);
    txf(1'b0, 1'b0, 5'd2);
    rd(12'h024, 32'd3);
    rd(12'h028, 32'd1);
    $display("transmit count done");
  endtask : t_tx
  task t_sat;
    wr(12'h024, 32'h00FF_FFFF);
    rd(12'h024, 32'd0);
    wr(12'h02C, 32'h80);
    wr(12'h024, 32'h00FF_FFFF);
    wr(12'h028, 32'h0000_FFFF);
    wr(12'h02C, 32'h0);
    txf(1'b0, 1'b0, 5'd1);
    txf(1'b0, 1'b0, 5'd1);
    rd(12'h024, 32'h00FF_FFFF);
    rd(12'h028, 32'h0000_FFFF);
    $display("saturation done");
  endtask : t_sat
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rx_dest} = '0;
    rx_evt = '0;
    tx_evt = '0;
    fails = 0;
    checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_match;
    t_clk;
    t_rx;
    t_tx;
    t_sat;
    close_out;
  end
endmodule : tb_top
